// *** src/pga_gain_trim_map.svh ***
// Register offsets, field positions and reset values of the gain and trim controls
`ifndef PGA_GAIN_TRIM_MAP_SVH
`define PGA_GAIN_TRIM_MAP_SVH
`define PGA_OFS_RESULT_LOW      4'h0
`define PGA_OFS_GAIN_CONTROL    4'h1
`define PGA_OFS_NCHAN_TRIM      4'h2
`define PGA_OFS_PCHAN_TRIM      4'h3
`define PGA_OFS_RESULT_HIGH     4'h4
`define PGA_GAIN_CONTROL_RESET  8'h00
`define PGA_TRIM_RESET          8'h40
`define PGA_GAIN_RSVD_MASK      8'h18
`define PGA_BIT_AMP_ENABLE      7
`define PGA_BIT_TEMP_ENABLE     6
`define PGA_BIT_TRIM_MODE       5
`define PGA_BIT_CAL_ENABLE      7
`define PGA_BIT_TRIM_SIGN       6
`define PGA_SETTLE_OPEN_LOOP_US 1050
`define PGA_SETTLE_BYPASS_US    8'h00
`define PGA_SETTLE_X1_US        8'h00
`define PGA_SETTLE_X2_US        8'h09
`define PGA_SETTLE_X5_US        8'h06
`define PGA_SETTLE_X10_US       8'h05
`define PGA_SETTLE_X20_US       8'h10
`define PGA_SETTLE_X49_US       8'h19
`define PGA_SETTLE_X98_US       8'h2d
`define PGA_SETTLE_SATURATED    8'hff
`define PGA_CLOCK_MHZ           20
`endif

// *** src/pga_gain_trim_pkg.sv ***
// Types shared by the gain and trim control block
package pga_gain_trim_pkg;
  typedef enum logic [2:0] {
    GAIN_BYPASS = 3'b000,
    GAIN_X1     = 3'b001,
    GAIN_X2     = 3'b010,
    GAIN_X5     = 3'b011,
    GAIN_X10    = 3'b100,
    GAIN_X20    = 3'b101,
    GAIN_X49    = 3'b110,
    GAIN_X98    = 3'b111
  } gain_select_t;
  typedef struct packed {
    logic       standalone_amp_enable;
    logic       temp_sensor_enable;
    logic       trim_mode;
    logic [1:0] reserved;
    logic [2:0] gain_select;
  } gain_control_t;
  typedef struct packed {
    logic       cal_enable;
    logic       sign;
    logic [5:0] magnitude;
  } trim_t;
  typedef struct packed {
    logic       amp_enable;
    logic       amp_bypass;
    logic       open_loop;
    logic       inputs_shorted;
    logic [6:0] gain_factor;
    logic       mux_disable;
    logic       low_cal_reference;
    logic       high_cal_reference;
  } amp_config_t;
endpackage

// *** src/pga_gain_trim_control.sv ***
// Gain, bypass, trim configuration and offset trim registers of the gain amplifier
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "pga_gain_trim_map.svh"

module pga_gain_trim_control
(
  // Clock and reset
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  // Register port
  input  wire logic [3:0]                        reg_addr,
  input  wire logic [7:0]                        reg_wdata,
  input  wire logic                              reg_write,
  input  wire logic                              reg_read,
  output logic      [7:0]                        reg_rdata,
  // Converter result capture
  input  wire logic                              result_load,
  input  wire logic [9:0]                        result_value,
  // Analog control outputs
  output pga_gain_trim_pkg::amp_config_t         amp_config,
  output logic                                   standalone_amp_enable,
  output logic                                   temp_sensor_enable,
  output logic      [6:0]                        nchan_trim_value,
  output logic      [6:0]                        pchan_trim_value,
  output logic      [7:0]                        settle_time_us
);

  pga_gain_trim_pkg::gain_control_t gain_reg;
  pga_gain_trim_pkg::gain_control_t gain_next;
  pga_gain_trim_pkg::trim_t         ntrim_reg;
  pga_gain_trim_pkg::trim_t         ntrim_next;
  pga_gain_trim_pkg::trim_t         ptrim_reg;
  pga_gain_trim_pkg::trim_t         ptrim_next;
  logic [9:0]                       result_reg;
  logic [9:0]                       result_next;
  logic [7:0]                       rdata_reg;
  logic [7:0]                       rdata_next;
  pga_gain_trim_pkg::amp_config_t   cfg_reg;
  pga_gain_trim_pkg::amp_config_t   cfg_next;
  logic [7:0]                       settle_reg;
  logic [7:0]                       settle_next;

  // Address decode
  wire logic sel_result_low  = reg_addr == `PGA_OFS_RESULT_LOW;
  wire logic sel_gain        = reg_addr == `PGA_OFS_GAIN_CONTROL;
  wire logic sel_ntrim       = reg_addr == `PGA_OFS_NCHAN_TRIM;
  wire logic sel_ptrim       = reg_addr == `PGA_OFS_PCHAN_TRIM;
  wire logic sel_result_high = reg_addr == `PGA_OFS_RESULT_HIGH;
  wire logic wr_gain         = reg_write && sel_gain;
  wire logic wr_ntrim        = reg_write && sel_ntrim;
  wire logic wr_ptrim        = reg_write && sel_ptrim;
  wire logic wr_res_low      = reg_write && sel_result_low;
  wire logic wr_res_high     = reg_write && sel_result_high;

  // Register next values; reserved bits are stored as written so software sees its own mistake
  assign gain_next  = wr_gain  ? pga_gain_trim_pkg::gain_control_t'(reg_wdata) : gain_reg;
  assign ntrim_next = wr_ntrim ? pga_gain_trim_pkg::trim_t'(reg_wdata) : ntrim_reg;
  assign ptrim_next = wr_ptrim ? pga_gain_trim_pkg::trim_t'(reg_wdata) : ptrim_reg;

  // Result capture: hardware load wins over a software write in the same cycle
  assign result_next = result_load ? result_value :
                       wr_res_high ? {reg_wdata, result_reg[1:0]} :
                       wr_res_low  ? {result_reg[9:2], reg_wdata[7:6]} :
                       result_reg;

  // Read mux, unmapped addresses read zero
  // low result format
  wire logic [7:0] rd_result_low  = {result_reg[1:0], 6'h00};
  wire logic [7:0] rd_result_high = result_reg[9:2];
  assign rdata_next = !reg_read       ? 8'h00 :
                      sel_result_low  ? rd_result_low :
                      sel_gain        ? gain_reg :
                      sel_ntrim       ? ntrim_reg :
                      sel_ptrim       ? ptrim_reg :
                      sel_result_high ? rd_result_high :
                      8'h00;

  // Amplifier mode decode
  // trim overrides gain
  wire logic       trim_on    = gain_reg.trim_mode;
  wire logic       bypass_on  = !trim_on && (gain_reg.gain_select == 3'b000);
  logic [6:0]      gain_factor;
  logic [7:0]      settle_us;

  // gain code table; bypass shows a zero factor
  always_comb
  begin
    gain_factor = 7'h00;
    case (pga_gain_trim_pkg::gain_select_t'(gain_reg.gain_select))
      pga_gain_trim_pkg::GAIN_BYPASS:
      begin
        gain_factor = 7'h00;
      end
      pga_gain_trim_pkg::GAIN_X1:
      begin
        gain_factor = 7'h01;
      end
      pga_gain_trim_pkg::GAIN_X2:
      begin
        gain_factor = 7'h02;
      end
      pga_gain_trim_pkg::GAIN_X5:
      begin
        gain_factor = 7'h05;
      end
      pga_gain_trim_pkg::GAIN_X10:
      begin
        gain_factor = 7'h0a;
      end
      pga_gain_trim_pkg::GAIN_X20:
      begin
        gain_factor = 7'h14;
      end
      pga_gain_trim_pkg::GAIN_X49:
      begin
        gain_factor = 7'h31;
      end
      pga_gain_trim_pkg::GAIN_X98:
      begin
        gain_factor = 7'h62;
      end
      default:
      begin
        gain_factor = 7'h00;
      end
    endcase
  end

  // Settling hint for software; gain 1 is slew limited, so it reads zero and software must judge
  always_comb
  begin
    settle_us = `PGA_SETTLE_BYPASS_US;
    case (pga_gain_trim_pkg::gain_select_t'(gain_reg.gain_select))
      pga_gain_trim_pkg::GAIN_BYPASS:
      begin
        settle_us = `PGA_SETTLE_BYPASS_US;
      end
      pga_gain_trim_pkg::GAIN_X1:
      begin
        settle_us = `PGA_SETTLE_X1_US;
      end
      pga_gain_trim_pkg::GAIN_X2:
      begin
        settle_us = `PGA_SETTLE_X2_US;
      end
      pga_gain_trim_pkg::GAIN_X5:
      begin
        settle_us = `PGA_SETTLE_X5_US;
      end
      pga_gain_trim_pkg::GAIN_X10:
      begin
        settle_us = `PGA_SETTLE_X10_US;
      end
      pga_gain_trim_pkg::GAIN_X20:
      begin
        settle_us = `PGA_SETTLE_X20_US;
      end
      pga_gain_trim_pkg::GAIN_X49:
      begin
        settle_us = `PGA_SETTLE_X49_US;
      end
      pga_gain_trim_pkg::GAIN_X98:
      begin
        settle_us = `PGA_SETTLE_X98_US;
      end
      default:
      begin
        settle_us = `PGA_SETTLE_BYPASS_US;
      end
    endcase
  end

  // Open-loop settling exceeds eight bits; it saturates and software must use the long wait
  assign settle_next = trim_on ? `PGA_SETTLE_SATURATED : settle_us;

  // Analog configuration; references follow their enable bits, trimming only makes sense in trim mode
  // inputs shorted
  assign cfg_next.inputs_shorted     = trim_on;
  assign cfg_next.open_loop          = trim_on;
  assign cfg_next.amp_enable         = !bypass_on;
  assign cfg_next.amp_bypass         = bypass_on;
  assign cfg_next.gain_factor        = trim_on ? 7'h00 : gain_factor;
  assign cfg_next.low_cal_reference  = ntrim_reg.cal_enable;
  assign cfg_next.high_cal_reference = ptrim_reg.cal_enable;
  assign cfg_next.mux_disable        = ntrim_reg.cal_enable || ptrim_reg.cal_enable;

  // Gain control register; reserved bits kept as written
  // clears on reset
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      gain_reg <= `PGA_GAIN_CONTROL_RESET;
    end
    else
    begin
      gain_reg <= gain_next;
    end
  end

  // N-pair trim register; volatile, so calibration is lost on reset
  // loads 40 on reset
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ntrim_reg <= `PGA_TRIM_RESET;
    end
    else
    begin
      ntrim_reg <= ntrim_next;
    end
  end

  // P-pair trim register, same volatile behaviour
  // loads 40 on reset
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ptrim_reg <= `PGA_TRIM_RESET;
    end
    else
    begin
      ptrim_reg <= ptrim_next;
    end
  end

  // Conversion result; cleared on reset only so that reads are never unknown
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      result_reg <= 10'h000;
    end
    else
    begin
      result_reg <= result_next;
    end
  end

  // Read data, standing one cycle after the read strobe
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // Analog configuration, one cycle behind the registers to keep the pins glitch free
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cfg_reg <= '0;
    end
    else
    begin
      cfg_reg <= cfg_next;
    end
  end

  // Settling hint register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      settle_reg <= 8'h00;
    end
    else
    begin
      settle_reg <= settle_next;
    end
  end

  // Outputs, all from flip-flops
  // stand-alone amp
  assign standalone_amp_enable = gain_reg.standalone_amp_enable;
  assign temp_sensor_enable    = gain_reg.temp_sensor_enable;
  assign nchan_trim_value      = {ntrim_reg.sign, ntrim_reg.magnitude};
  assign pchan_trim_value      = {ptrim_reg.sign, ptrim_reg.magnitude};
  assign amp_config            = cfg_reg;
  assign settle_time_us        = settle_reg;
  assign reg_rdata             = rdata_reg;

endmodule

// *** dv/pga_gain_trim_control_sva.sv ***
// Assertion checker for the gain and trim control block
`timescale 1ns/1ns
module pga_gain_trim_checker
(
  // Clock, reset and register port
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // Control outputs
  input wire pga_gain_trim_pkg::amp_config_t amp_config,
  input wire logic       standalone_amp_enable,
  input wire logic       temp_sensor_enable,
  input wire logic [6:0] nchan_trim_value,
  input wire logic [6:0] pchan_trim_value
);
  // Gain factor for each code; bypass shows zero
  localparam logic [6:0] GTAB [8] = '{7'h00, 7'h01, 7'h02, 7'h05, 7'h0a, 7'h14, 7'h31, 7'h62};
  logic gw;
  logic nw;
  // Writes to gain control and N trim
  assign gw = reg_write && reg_addr == 4'h1;
  assign nw = reg_write && reg_addr == 4'h2;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A second write would move the config before it is seen
  sequence s_quiet;
    !reg_write;
  endsequence
  a_reset_values: assert property (
    $rose(rst_n) |-> nchan_trim_value == 7'h40 && pchan_trim_value == 7'h40 && !standalone_amp_enable
    && !temp_sensor_enable) else $error("reset values wrong");
  a_bypass_gain: assert property (
    gw && !reg_wdata[5] && reg_wdata[2:0] == 3'h0 ##1 s_quiet |=> amp_config.amp_bypass
    && !amp_config.amp_enable) else $error("bypass not taken");
  a_gain_factor: assert property (
    gw && !reg_wdata[5] ##1 s_quiet |=> amp_config.gain_factor == GTAB[$past(reg_wdata[2:0], 2)])
    else $error("gain factor wrong");
  a_trim_open: assert property (
    gw && reg_wdata[5] ##1 s_quiet |=> amp_config.open_loop && amp_config.inputs_shorted
    && amp_config.amp_enable && amp_config.gain_factor == 7'h00) else $error("trim config wrong");
  a_amp_bits: assert property (
    gw |=> standalone_amp_enable == $past(reg_wdata[7]) && temp_sensor_enable == $past(reg_wdata[6]))
    else $error("enable bits wrong");
  a_cal_low: assert property (
    nw && reg_wdata[7] ##1 s_quiet |=> amp_config.low_cal_reference && amp_config.mux_disable)
    else $error("low reference not on");
  a_trim_value: assert property (
    nw |=> nchan_trim_value == $past(reg_wdata[6:0])) else $error("N trim value wrong");
  a_low_result: assert property (
    reg_read && reg_addr == 4'h0 |=> reg_rdata[5:0] == 6'h00) else $error("low result bits not zero");
  a_trim_read: assert property (
    reg_read && reg_addr == 4'h3 |=> reg_rdata[6:0] == $past(pchan_trim_value)) else $error("P trim read wrong");
endmodule

bind pga_gain_trim_control pga_gain_trim_checker checker_inst (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .amp_config, .standalone_amp_enable, .temp_sensor_enable, .nchan_trim_value,
  .pchan_trim_value);

// *** dv/test_pga_gain_trim_control.sv ***
// Self-checking bench for the gain and trim control block
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_pga_gain_trim_control;
  logic                           clock = 1'h0;
  logic                           rst_n = 1'h0;
  logic [3:0]                     reg_addr = 4'h0;
  logic [7:0]                     reg_wdata = 8'h00;
  logic                           reg_write = 1'h0;
  logic                           reg_read = 1'h0;
  logic                           result_load = 1'h0;
  logic [9:0]                     result_value = 10'h000;
  logic [7:0]                     reg_rdata;
  logic [7:0]                     settle_time_us;
  logic [6:0]                     nchan_trim_value;
  logic [6:0]                     pchan_trim_value;
  logic                           standalone_amp_enable;
  logic                           temp_sensor_enable;
  pga_gain_trim_pkg::amp_config_t amp_config;
  int                             n_mismatch = 0;
  int                             cmp_count = 0;
  logic [6:0]                     gtab [8] = '{7'h00, 7'h01, 7'h02, 7'h05, 7'h0a, 7'h14, 7'h31, 7'h62};
  // Settling hint per gain code in microseconds, gain 1 slew limited
  logic [7:0]                     stab [8] = '{8'h00, 8'h00, 8'h09, 8'h06, 8'h05, 8'h10, 8'h19, 8'h2d};

  pga_gain_trim_control dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .result_load, .result_value, .amp_config, .standalone_amp_enable, .temp_sensor_enable,
    .nchan_trim_value, .pchan_trim_value, .settle_time_us);

  // 50 ns period
  always #25 clock = ~clock;

  task automatic do_reset;
    @(posedge clock);
    rst_n <= 1'h0;
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clock);
    reg_read <= 1'h0;
    #1 `CHK(reg_rdata, e)
  endtask
  // Config lags the register by one more cycle
  task automatic wait2;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic t_reset;
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h40);
    rd(4'h3, 8'h40);
    `CHK({standalone_amp_enable, temp_sensor_enable, amp_config.amp_bypass}, 3'h1)
  endtask
  // no conversion started, so no differential, sensor or mux-out use
  task automatic t_gain;
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h1, {i[1:0], 3'h0, i[2:0]});
      wait2;
      `CHK(settle_time_us, stab[i])
      `CHK(amp_config.gain_factor, gtab[i])
      `CHK({amp_config.amp_bypass, amp_config.amp_enable}, (i == 0) ? 2'h2 : 2'h1)
      `CHK({standalone_amp_enable, temp_sensor_enable}, i[1:0])
    end
  endtask
  task automatic t_trim;
    wr(4'h1, 8'h27);
    wait2;
    `CHK({amp_config.open_loop, amp_config.inputs_shorted, amp_config.amp_enable}, 3'h7)
    `CHK(amp_config.gain_factor, 7'h00)
    `CHK(settle_time_us, 8'hff)
    wr(4'h1, 8'h07);
    wait2;
    `CHK(amp_config.open_loop, 1'h0)
  endtask
  task automatic t_cal;
    wr(4'h2, 8'hc0);
    wr(4'h3, 8'hbf);
    wait2;
    `CHK({amp_config.low_cal_reference, amp_config.high_cal_reference, amp_config.mux_disable}, 3'h7)
    `CHK(nchan_trim_value, 7'h40)
    `CHK(pchan_trim_value, 7'h3f)
    rd(4'h2, 8'hc0);
    rd(4'h3, 8'hbf);
    wr(4'h2, 8'h3f);
    wait2;
    `CHK({amp_config.low_cal_reference, amp_config.high_cal_reference, amp_config.mux_disable}, 3'h3)
  endtask
  task automatic t_result;
    @(posedge clock);
    result_value <= 10'h2c1;
    result_load <= 1'h1;
    @(posedge clock);
    result_load <= 1'h0;
    rd(4'h0, 8'h40);
    rd(4'h4, 8'hb0);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'hc0);
    wr(4'h4, 8'h5a);
    rd(4'h4, 8'h5a);
    rd(4'h0, 8'hc0);
    // Hardware load and software write of the result in one cycle: the load wins
    @(posedge clock);
    reg_addr <= 4'h4;
    reg_wdata <= 8'h00;
    reg_write <= 1'h1;
    result_value <= 10'h3fe;
    result_load <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
    result_load <= 1'h0;
    rd(4'h4, 8'hff);
    rd(4'h0, 8'h80);
    // both amplifiers off before power save
    wr(4'h1, 8'h00);
    wait2;
    `CHK({standalone_amp_enable, temp_sensor_enable, amp_config.amp_enable}, 3'h0)
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence, with a second reset in mid-run
  initial
  begin
    do_reset;
    t_reset;
    t_gain;
    t_trim;
    t_cal;
    t_result;
    do_reset;
    t_reset;
    report_and_stop;
  end
  // Watchdog: the tests need about 110 cycles
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
